// ===== rtl/watchdog_timer.sv
/*
  Watchdog timer with reset-cause status, reached over AXI4-Lite.
  Assumes: aresetn is the power-on reset; sys_reset pulses for any later
  chip reset; restart, interrupt acknowledge and reset events come from
  logic on aclk; wdt_osc is a free running 128 kHz clock from a pin.
*/
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
// Behaviour
// - counter advances on 128 kHz oscillator edges
// - counter zeroed by restart, disable, reset
// - ten time-outs; reset-mode expiry resets chip
// - fuse picks level; level 2 starts enabled
// - level 1: writing enable one enables freely
// - level 2: always runs, enable reads one
// - level 2: prescale changes only via window
// - change-enable self-clears four cycles later
// - enable clears only inside change window
// - level 2: no write disables the watchdog
// - level 1: watchdog flag forces enable on
// - enable and irq-enable select the mode
// - both set: time-out clears irq-enable
// - irq flag sets on time-out, clears on ack
// - irq needs flag, irq-enable, global enable
// - cause flags set on cause, clear zero/POR
// - power-on flag clears only by software
// - cause bits seven to four read zero
// - prescale 2K to 1024K ticks, reserved clamp
// - reset pulse lasts one system clock
`timescale 1ns/1ps
`include "wdt_consts.svh"

module watchdog_timer
  import wdt_pkg::*;
#(
  parameter int          ADDR_W     = 4,
  parameter int          CNT_W      = 21,
  parameter int unsigned BASE_TICKS = `WDT_BASE_TICKS
) (
  // clock, reset and enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // write address channel
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output      logic              awready,
  // write data channel
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output      logic              wready,
  // write response channel
  output      logic [1:0]        bresp,
  output      logic              bvalid,
  input  wire logic              bready,
  // read address channel
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output      logic              arready,
  // read data channel
  output      logic [31:0]       rdata,
  output      logic [1:0]        rresp,
  output      logic              rvalid,
  input  wire logic              rready,
  // core and reset controller side
  input  wire logic              safety_level_fuse,
  input  wire logic              wdt_osc,
  input  wire logic              restart_instruction,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_taken,
  input  wire logic              sys_reset,
  input  wire logic              brownout_event,
  input  wire logic              pin_reset_event,
  // watchdog outputs
  output      logic              wdt_irq,
  output      logic              wdt_reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              osc_s1_r, osc_s2_r, osc_s3_r; // oscillator sync
  logic [CNT_W-1:0]  cnt_r;        // oscillator ticks since restart
  logic              level2_r;     // latched safety level fuse
  logic              wde_r;        // stored enable bit
  logic              timeout_irq_enable_r;       // time-out irq enable
  logic              timeout_irq_flag_r;       // time-out irq flag
  logic              change_enable_bit_r;       // change enable bit
  logic              arm_r;        // window opened by a proper first write
  logic [2:0]        ce_cnt_r;     // cycles left for change enable
  logic [3:0]        psel_r;       // prescale select as written
  cause_t            cause_r;      // reset-cause flags
  logic              irq_r;        // registered interrupt request
  logic              rst_r;        // registered reset pulse
  logic [ADDR_W-1:0] awaddr_r;     // captured write address
  logic [7:0]        wdat_r;       // captured low write byte
  logic              wstb_r;       // low byte lane strobe
  logic              aw_have_r, w_have_r;
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;

  // ----------------------------------------------------------------
  // oscillator edge detect
  // ----------------------------------------------------------------
  // the first stage feeds only the second; the edge is taken on stage two
  wire tick = osc_s2_r & ~osc_s3_r;

  // ----------------------------------------------------------------
  // mode and time-out decode
  // ----------------------------------------------------------------
  // level 1 lets the watchdog cause flag hold enable on so a failing
  // boot keeps resetting instead of silently running unguarded
  wire              wde_eff = level2_r | wde_r | cause_r.wd;
  wire              running = wde_eff | timeout_irq_enable_r;
  wire [3:0]        sel_eff = (psel_r > `WDT_MAX_SEL) ? `WDT_MAX_SEL
                                                      : psel_r;
  wire [CNT_W-1:0]  limit   = CNT_W'(BASE_TICKS) << sel_eff;
  wire              tmo     = tick & running & ~restart_instruction &
                              ~sys_reset & (cnt_r == limit - 1'b1);
  wire              tmo_irq = tmo & timeout_irq_enable_r;
  wire              tmo_rst = tmo & wde_eff & ~timeout_irq_enable_r;
  wire              cnt_clr = ~running | restart_instruction | sys_reset;

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  wire wr_fire  = aw_have_r & w_have_r & ~bvalid_r;
  wire wr_ctl   = wr_fire & wstb_r & (awaddr_r == `WDT_OFS_CTRL);
  wire wr_cause = wr_fire & wstb_r & (awaddr_r == `WDT_OFS_CAUSE);
  wire wr_map   = (awaddr_r == `WDT_OFS_CTRL) |
                  (awaddr_r == `WDT_OFS_CAUSE);
  wire ce_last  = (ce_cnt_r == 3'h1);
  // second write of the timed sequence: window open, change bit low
  wire arm_ok   = wr_ctl & change_enable_bit_r & arm_r & ~wdat_r[`WDT_B_CE];
  wire [3:0] psel_wr = {wdat_r[`WDT_B_P3], wdat_r[`WDT_B_P2:`WDT_B_P0]};

  // ----------------------------------------------------------------
  // control next values
  // ----------------------------------------------------------------
  // enable may drop only in the window and with the cause flag clear;
  // at level 2 the stored bit is never used
  wire wde_nxt  = (~wr_ctl | level2_r) ? wde_r :
                  wdat_r[`WDT_B_EN] ? 1'b1 :
                  (arm_ok & ~cause_r.wd) ? 1'b0 :
                  wde_r;
  // level 1 takes prescale freely, level 2 only in the window
  wire psel_we  = wr_ctl & (~level2_r | arm_ok);
  wire change_enable_bit_nxt = wr_ctl ? wdat_r[`WDT_B_CE] :
                  (ce_last ? 1'b0 : change_enable_bit_r);
  wire arm_nxt  = wr_ctl ? (wdat_r[`WDT_B_CE] & wdat_r[`WDT_B_EN]) :
                  (ce_last ? 1'b0 : arm_r);
  wire [2:0] ce_cnt_nxt = (wr_ctl & wdat_r[`WDT_B_CE]) ? `WDT_CE_HOLD :
                  (ce_cnt_r != 3'h0) ? ce_cnt_r - 3'h1 : 3'h0;
  // software writing irq-enable overrides the same-cycle auto clear
  wire timeout_irq_enable_nxt = wr_ctl ? wdat_r[`WDT_B_IE] :
                  (tmo & wde_eff) ? 1'b0 : timeout_irq_enable_r;
  // a new time-out wins over a clear in the same cycle
  wire timeout_irq_flag_clr = (wr_ctl & wdat_r[`WDT_B_IF]) | irq_vector_taken;
  wire timeout_irq_flag_nxt = tmo_irq | (timeout_irq_flag_r & ~timeout_irq_flag_clr);

  // ----------------------------------------------------------------
  // reset-cause next values: set wins over software zero
  // ----------------------------------------------------------------
  wire    clr_ok = ~wr_cause;
  cause_t cause_nxt;
  assign cause_nxt.wd  = tmo_rst | (cause_r.wd &
                         (clr_ok | wdat_r[`WDT_B_WATCHDOG_CAUSE_FLAG]));
  assign cause_nxt.bo  = brownout_event | (cause_r.bo &
                         (clr_ok | wdat_r[`WDT_B_BROWNOUT_CAUSE_FLAG]));
  assign cause_nxt.pin = pin_reset_event | (cause_r.pin &
                         (clr_ok | wdat_r[`WDT_B_PIN_CAUSE_FLAG]));
  assign cause_nxt.po  = cause_r.po &
                         (clr_ok | wdat_r[`WDT_B_POWERON_CAUSE_FLAG]);

  // ----------------------------------------------------------------
  // read mux: reserved bits read zero
  // ----------------------------------------------------------------
  wire [7:0] ctl_view   = {timeout_irq_flag_r, timeout_irq_enable_r, psel_r[3], change_enable_bit_r,
                           wde_eff, psel_r[2:0]};
  wire [7:0] cause_view = {4'h0, cause_r};
  wire       rd_ctl     = (araddr == `WDT_OFS_CTRL);
  wire       rd_cause   = (araddr == `WDT_OFS_CAUSE);
  wire [31:0] rd_mux    = rd_ctl   ? {24'h0, ctl_view} :
                          rd_cause ? {24'h0, cause_view} : 32'h0;

  // ----------------------------------------------------------------
  // oscillator synchroniser and tick counter
  // ----------------------------------------------------------------
  // the oscillator is slow against aclk, so edges are counted as enables
  // rather than clocking logic directly; no signal lives in two domains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      cnt_r    <= '0;
    end else if (ce) begin
      osc_s1_r <= wdt_osc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      if (cnt_clr || tmo) begin
        cnt_r <= '0;
      end else if (tick) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register and outputs
  // ----------------------------------------------------------------
  // the fuse is caught while reset is held, never by an async path
  always_ff @(posedge aclk) begin
    if (!aresetn || (ce && sys_reset)) begin
      level2_r <= safety_level_fuse;
      wde_r    <= 1'b0;
      timeout_irq_enable_r   <= 1'b0;
      timeout_irq_flag_r   <= 1'b0;
      change_enable_bit_r   <= 1'b0;
      arm_r    <= 1'b0;
      ce_cnt_r <= 3'h0;
      psel_r   <= `WDT_PSEL_RST;
      irq_r    <= 1'b0;
      rst_r    <= 1'b0;
    end else if (ce) begin
      wde_r    <= wde_nxt;
      timeout_irq_enable_r   <= timeout_irq_enable_nxt;
      timeout_irq_flag_r   <= timeout_irq_flag_nxt;
      change_enable_bit_r   <= change_enable_bit_nxt;
      arm_r    <= arm_nxt;
      ce_cnt_r <= ce_cnt_nxt;
      if (psel_we) begin
        psel_r <= psel_wr;
      end
      irq_r    <= timeout_irq_flag_r & timeout_irq_enable_r & global_irq_enable;
      rst_r    <= tmo_rst;
    end
  end

  // ----------------------------------------------------------------
  // reset-cause flags survive chip resets; only power-on reset or a software zero clears them
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= '{wd: 1'b0, bo: 1'b0, pin: 1'b0, po: 1'b1};
    end else if (ce) begin
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write side: address and data taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdat_r    <= 8'h00;
      wstb_r    <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready_r) begin
        awaddr_r  <= awaddr;
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wdat_r   <= wdata[7:0];
        wstb_r   <= wstrb[0];
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      // accept the next write only once the response has gone
      if (bvalid_r && bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side: one read in flight
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_r) begin
        rdata_r   <= rd_mux;
        rresp_r   <= (rd_ctl | rd_cause) ? RESP_OKAY : RESP_SLVERR;
        rvalid_r  <= 1'b1;
        arready_r <= 1'b0;
      end else if (rvalid_r && rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // output wiring: every output is a flip-flop
  // ----------------------------------------------------------------
  assign awready   = awready_r;
  assign wready    = wready_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign arready   = arready_r;
  assign rvalid    = rvalid_r;
  assign rdata     = rdata_r;
  assign rresp     = rresp_r;
  assign wdt_irq   = irq_r;
  assign wdt_reset = rst_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_one_cycle: assert property (
    rst_r |=> !rst_r
  ) else $error("watchdog reset pulse longer than one cycle");

  a_expiry_resets: assert property (
    (ce && tmo && wde_eff && !timeout_irq_enable_r) |=> (rst_r && cause_r.wd)
  ) else $error("reset-mode expiry did not reset");

  a_cnt_held_zero: assert property (
    (ce && (!running || restart_instruction)) |=> (cnt_r == '0)
  ) else $error("counter not zeroed when stopped or restarted");

  a_change_enable_bit_autoclear: assert property (
    (ce && wr_ctl && wdat_r[`WDT_B_CE]) ##1 (ce && !wr_ctl)[*4]
      |=> !change_enable_bit_r
  ) else $error("change enable not cleared after four cycles");

  a_level2_enabled: assert property (
    (rvalid_r && $past(rd_ctl && arvalid && arready_r) && level2_r)
      |-> rdata_r[`WDT_B_EN]
  ) else $error("enable read zero at level two");

  a_timeout_irq_enable_autoclear: assert property (
    (ce && tmo && wde_eff && timeout_irq_enable_r && !wr_ctl) |=> !timeout_irq_enable_r && timeout_irq_flag_r
  ) else $error("irq enable not cleared on time-out");

  a_irq_gated: assert property (
    irq_r |-> $past(timeout_irq_flag_r && timeout_irq_enable_r && global_irq_enable)
  ) else $error("interrupt without flag, enable and global enable");

  a_cause_rsv_zero: assert property (
    (rvalid_r && $past(rd_cause && arvalid && arready_r))
      |-> (rdata_r[7:4] == 4'h0)
  ) else $error("reserved cause bits read nonzero");

  a_por_flag_set: assert property (
    $rose(aresetn) |-> cause_r.po
  ) else $error("power-on flag not set after power-on reset");

  a_watchdog_cause_flag_forces_en: assert property (
    (ce && cause_r.wd && wr_ctl && !wdat_r[`WDT_B_EN]) |=> wde_eff
  ) else $error("enable cleared while watchdog flag set");

endmodule // watchdog_timer

// ===== rtl/wdt_consts.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  watchdog timer.
  Assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define WDT_OFS_CAUSE   4'h0
`define WDT_OFS_CTRL    4'h4

// ----------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------
`define WDT_B_IF        7
`define WDT_B_IE        6
`define WDT_B_P3        5
`define WDT_B_CE        4
`define WDT_B_EN        3
`define WDT_B_P2        2
`define WDT_B_P0        0

// ----------------------------------------------------------------
// reset-cause field positions
// ----------------------------------------------------------------
`define WDT_B_WATCHDOG_CAUSE_FLAG      3
`define WDT_B_BROWNOUT_CAUSE_FLAG      2
`define WDT_B_PIN_CAUSE_FLAG     1
`define WDT_B_POWERON_CAUSE_FLAG      0

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define WDT_PSEL_RST    4'h0
`define WDT_MAX_SEL     4'h9
`define WDT_CE_HOLD     3'h4
`define WDT_OSC_KHZ     128
`define WDT_BASE_TICKS  2048

`endif

// ===== rtl/wdt_pkg.sv
/*
  Types shared by the watchdog timer: bus answers and reset-cause flags.
  Assumes the constants header is on the include path.
*/
package wdt_pkg;

  // ----------------------------------------------------------------
  // bus response codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;

  // ----------------------------------------------------------------
  // reset-cause flags, packed in register order
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wd;   // watchdog reset seen
    logic bo;   // brown-out reset seen
    logic pin;  // external pin reset seen
    logic po;   // power-on reset seen
  } cause_t;

endpackage

// ===== sim/wdt_osc_model.sv
/*
  Model of the on-chip watchdog oscillator that feeds the timer.
  Assumes the timer samples the pin and counts its rising edges.
*/
`timescale 1ns/1ps

module wdt_osc_model #(
  parameter real HALF_NS = 3906.25  // half period of a 128 kHz clock
) (
  // oscillator pin
  output logic osc
);
  // ------------------------------------------------------------
  // free running clock
  // ------------------------------------------------------------
  // runs from time zero, with no phase tie to the system clock
  initial begin
    osc = 1'b0;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule // wdt_osc_model

// ===== sim/watchdog_timer_tb.sv
/*
  Self-checking bench of the watchdog timer: each bus access notes its
  expected answer in a queue, a monitor checks answers as they appear.
  Assumes the package, the design and the oscillator model come first.
*/
`timescale 1ns/1ps
`include "wdt_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin \
  $display("mismatch %s exp %0h got %0h", nm, e, g); n_errors++; end end

module watchdog_timer_tb;
  import wdt_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        fuse, osc, restart, gie, vec_taken, bo_ev, pin_ev;
  logic        wdt_irq, wdt_reset;
  logic [33:0] rq[$];       // expected {rresp, rdata}
  logic [1:0]  bq[$];       // expected bresp
  int          n_errors, n_compared, n_rst, k, i;

  // ------------------------------------------------------------
  // clock, design and oscillator
  // ------------------------------------------------------------
  always #20 aclk = ~aclk;  // 25 MHz

  watchdog_timer #(.BASE_TICKS(4)) i_watchdog_timer (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .safety_level_fuse(fuse), .wdt_osc(osc), .restart_instruction(restart),
    .global_irq_enable(gie), .irq_vector_taken(vec_taken),
    .sys_reset(1'b0), .brownout_event(bo_ev), .pin_reset_event(pin_ev),
    .wdt_irq(wdt_irq), .wdt_reset(wdt_reset));

  wdt_osc_model i_wdt_osc_model (.osc(osc));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    test_done();
  endtask

  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    bit aw, w;
    int t;
    bq.push_back(er);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1; aw = 1; w = 1; t = 0;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin aw = 0; awvalid <= 1'b0; end
      if (w && wready === 1'b1) begin w = 0; wvalid <= 1'b0; end
      if (++t > 100) hang();
    end
    do begin
      @(posedge aclk);
      if (++t > 100) hang();
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // one read, expected answer noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int t;
    rq.push_back({er, 24'h0, d});
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; t = 0;
    do begin
      @(posedge aclk);
      if (++t > 100) hang();
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      if (++t > 100) hang();
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // bounded wait for a reset pulse (rst=1) or a raised interrupt
  task automatic wait_ev(input bit rst, output int n);
    for (n = 0; n < 4000; n++) begin
      @(posedge aclk);
      if ((rst ? wdt_reset : wdt_irq) === 1'b1) break;
    end
    if (n == 4000) hang();
  endtask

  task automatic pulse_restart();
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // monitor: answers checked against the oldest note
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (wdt_reset === 1'b1) n_rst++;
    if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      `CHK("read", rq.pop_front(), {rresp, rdata})
    if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
      `CHK("bresp", bq.pop_front(), bresp)
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    fuse = 0; restart = 0; gie = 1; vec_taken = 0; bo_ev = 0; pin_ev = 0;
    seed = 32'd18618; n_errors = 0; n_compared = 0; n_rst = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // level 1 comes up disabled, power-on flag set
    rd(`WDT_OFS_CAUSE, 8'h01);
    rd(`WDT_OFS_CTRL, 8'h00);
    // interrupt mode, two prescale codes, two ways to clear the flag
    for (i = 0; i < 2; i++) begin
      wr(`WDT_OFS_CTRL, 8'h40 | i[7:0]);
      wait_ev(0, k);
      `CHK("irq time", 1'b1, (k > ((4 << i) - 1) * 195 - 10) && (k < (4 << i) * 196 + 20))
      rd(`WDT_OFS_CTRL, 8'hC0 | i[7:0]);
      gie <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK("irq gated", 1'b0, wdt_irq)
      gie <= 1'b1;
      if (i == 0) wr(`WDT_OFS_CTRL, 8'h80);
      else begin
        vec_taken <= 1'b1;
        @(posedge aclk);
        vec_taken <= 1'b0;
        wr(`WDT_OFS_CTRL, 8'h00);
      end
      rd(`WDT_OFS_CTRL, 8'h00);
    end
    // both bits: first time-out only sets the flag (irq-enable drops at
    // once, so no request reaches the pin), the second one resets
    wr(`WDT_OFS_CTRL, 8'h48);
    wait_ev(1, k);
    @(posedge aclk);
    `CHK("reset width", 1'b0, wdt_reset)
    `CHK("second expiry", 1'b1, (k > 7 * 195 - 10) && (k < 8 * 196 + 20))
    rd(`WDT_OFS_CTRL, 8'h88);
    pulse_restart();
    rd(`WDT_OFS_CAUSE, 8'h09);
    // watchdog flag still set: enable must survive the timed disable
    wr(`WDT_OFS_CTRL, 8'h18);
    wr(`WDT_OFS_CTRL, 8'h80);
    rd(`WDT_OFS_CTRL, 8'h08);
    wr(`WDT_OFS_CAUSE, 8'h00);
    rd(`WDT_OFS_CAUSE, 8'h00);
    wr(`WDT_OFS_CTRL, 8'h00);
    rd(`WDT_OFS_CTRL, 8'h08);
    // restarts at random spacing keep the reset away
    k = n_rst;
    for (i = 0; i < 12; i++) begin
      repeat (20 + xs() % 128) @(posedge aclk);
      pulse_restart();
    end
    `CHK("no reset", k, n_rst)
    wr(`WDT_OFS_CTRL, 8'h18);
    wr(`WDT_OFS_CTRL, 8'h00);
    rd(`WDT_OFS_CTRL, 8'h00);
    wr(`WDT_OFS_CTRL, 8'h08);
    rd(`WDT_OFS_CTRL, 8'h08);
    pulse_restart();
    wr(`WDT_OFS_CTRL, 8'h18);
    wr(`WDT_OFS_CTRL, 8'h00);
    // cause flags set by their event, cleared by writing zero
    bo_ev <= 1'b1; pin_ev <= 1'b1;
    @(posedge aclk);
    bo_ev <= 1'b0; pin_ev <= 1'b0;
    rd(`WDT_OFS_CAUSE, 8'h06);
    wr(`WDT_OFS_CAUSE, 8'hFC);
    rd(`WDT_OFS_CAUSE, 8'h04);
    // unmapped place refused
    wr(4'h8, 8'(xs() % 256), RESP_SLVERR);
    rd(4'hC, 8'h00, RESP_SLVERR);
    // level 2: always on, prescale changes only through the window
    fuse <= 1'b1; aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`WDT_OFS_CTRL, 8'h08);
    wr(`WDT_OFS_CTRL, 8'h18);
    rd(`WDT_OFS_CTRL, 8'h18);
    repeat (6) @(posedge aclk);
    rd(`WDT_OFS_CTRL, 8'h08);
    wr(`WDT_OFS_CTRL, 8'h18);
    wr(`WDT_OFS_CTRL, 8'h02);
    rd(`WDT_OFS_CTRL, 8'h0A);
    wr(`WDT_OFS_CTRL, 8'h05);
    rd(`WDT_OFS_CTRL, 8'h0A);
    wr(`WDT_OFS_CTRL, 8'h18);
    wr(`WDT_OFS_CTRL, 8'h00);
    rd(`WDT_OFS_CTRL, 8'h08);
    // start the count from zero so the expiry time is known
    pulse_restart();
    wait_ev(1, k);
    `CHK("level2 reset", 1'b1, (k > 3 * 195 - 10) && (k < 4 * 196 + 20))
    repeat (2) @(posedge aclk);
    test_done();
  end
endmodule // watchdog_timer_tb
